// *** swrm_monitor.sv ***
// Summary of operation
// - supply fault drops both resets same cycle
// - resets held during fault; release 50/60 ms
// - watchdog silent for timeout asserts both resets
// - watchdog reset: primary 50 ms, secondary +10
// - watchdog count restarts when primary releases
// - two selects choose 0.75/1.5/12.5/25 ms
// - every edge of activity line restarts count
module swrm_monitor
   import swrm_pkg::*;
#(
   parameter int unsigned PRIMARY_CYC   = swrm_pkg::PRIMARY_HOLD_CYC,
   parameter int unsigned SECONDARY_CYC = swrm_pkg::SECONDARY_EXTRA_CYC,
   parameter int unsigned WDT0_CYC      = swrm_pkg::WDT_SEL0_CYC,
   parameter int unsigned WDT1_CYC      = swrm_pkg::WDT_TIMEOUT_SELECT_LOW_CYC,
   parameter int unsigned WDT2_CYC      = swrm_pkg::WDT_TIMEOUT_SELECT_HIGH_CYC,
   parameter int unsigned WDT3_CYC      = swrm_pkg::WDT_SEL3_CYC
)
(
   // clock and reset
   input  wire logic                   sys_clk,
   input  wire logic                   arst_n,
   // supply comparator, high while supply is good
   input  wire logic                   monitored_supply,
   // processor side
   input  wire logic                   watchdog_activity_line,
   input  wire swrm_pkg::swrm_sel_type timeout_sel,
   // reset outputs, active low
   output swrm_pkg::swrm_rst_type      reset_out
);
   import swrm_pkg::*;

   logic                   supply_ok;
   logic                   wdi_sync;
   logic                   wdi_prev;
   logic                   wdi_edge;
   logic [CNT_W-1:0]       wdt_cnt;
   logic [CNT_W-1:0]       wdt_limit;
   logic [CNT_W-1:0]       hold_cnt;
   logic                   wdt_expire;
   swrm_state_type         state;
   swrm_state_type         next_state;
   logic                   sel_hi_s;
   logic                   sel_lo_s;

   swrm_sync u_sync_sup
   (
      .sys_clk  (sys_clk),
      .arst_n   (arst_n),
      .async_in (monitored_supply),
      .sync_out (supply_ok)
   );

   swrm_sync u_sync_wdi
   (
      .sys_clk  (sys_clk),
      .arst_n   (arst_n),
      .async_in (watchdog_activity_line),
      .sync_out (wdi_sync)
   );

   swrm_sync u_sync_shi
   (
      .sys_clk  (sys_clk),
      .arst_n   (arst_n),
      .async_in (timeout_sel.timeout_select_high),
      .sync_out (sel_hi_s)
   );

   swrm_sync u_sync_slo
   (
      .sys_clk  (sys_clk),
      .arst_n   (arst_n),
      .async_in (timeout_sel.timeout_select_low),
      .sync_out (sel_lo_s)
   );

   function automatic logic [CNT_W-1:0] pick_limit(input logic hi,
                                                  input logic lo);
      case ({hi, lo})
         2'b00:   pick_limit = CNT_W'(WDT0_CYC);
         2'b01:   pick_limit = CNT_W'(WDT1_CYC);
         2'b10:   pick_limit = CNT_W'(WDT2_CYC);
         default: pick_limit = CNT_W'(WDT3_CYC);
      endcase
   endfunction

   assign wdt_limit  = pick_limit(sel_hi_s, sel_lo_s);
   assign wdi_edge   = wdi_sync ^ wdi_prev;
   // watchdog runs whenever primary reset is released
   assign wdt_expire = (state == ST_RUN || state == ST_HOLD2)
                       && (wdt_cnt >= wdt_limit - 1'b1);

   // previous sample of the activity line
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         wdi_prev <= 1'b0;
      else
         wdi_prev <= wdi_sync;
   end

   // watchdog count, only runs with primary reset released
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         wdt_cnt <= '0;
      else if (!(state == ST_RUN || state == ST_HOLD2) || wdi_edge
               || !supply_ok)
         wdt_cnt <= '0;
      else if (!wdt_expire)
         wdt_cnt <= wdt_cnt + 1'b1;
   end

   always_comb
   begin
      next_state = state;
      case (state)
         ST_RUN:
            if (!supply_ok)
               next_state = ST_FAULT;
            else if (wdt_expire)
               next_state = ST_HOLD1;
         ST_FAULT:
            if (supply_ok)
               next_state = ST_HOLD1;
         ST_HOLD1:
            if (!supply_ok)
               next_state = ST_FAULT;
            else if (hold_cnt == CNT_W'(PRIMARY_CYC - 1))
               next_state = ST_HOLD2;
         ST_HOLD2:
            if (!supply_ok)
               next_state = ST_FAULT;
            else if (wdt_expire)
               next_state = ST_HOLD1;
            else if (hold_cnt == CNT_W'(SECONDARY_CYC - 1))
               next_state = ST_RUN;
         default:
            next_state = ST_FAULT;
      endcase
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         state <= ST_FAULT;
      else
         state <= next_state;
   end

   // hold timer, restarts on every state change
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         hold_cnt <= '0;
      else if (next_state != state)
         hold_cnt <= '0;
      else if (state == ST_HOLD1 || state == ST_HOLD2)
         hold_cnt <= hold_cnt + 1'b1;
   end

   // registered outputs; fault drops both in one cycle
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         reset_out <= '0;
      else
      begin
         reset_out.primary_reset_n   <= (next_state == ST_HOLD2) ||
                                        (next_state == ST_RUN);
         reset_out.secondary_reset_n <= (next_state == ST_RUN);
      end
   end

   both_low_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      $fell(supply_ok) |=> !reset_out.primary_reset_n
                           && !reset_out.secondary_reset_n)
      else $error("supply fault did not drop both resets");

   fault_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      !supply_ok |=> !reset_out.primary_reset_n)
      else $error("primary reset released during fault");

   order_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      reset_out.secondary_reset_n |-> reset_out.primary_reset_n)
      else $error("secondary released before primary");

   expire_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      wdt_expire && supply_ok |=> !reset_out.primary_reset_n
                                  && !reset_out.secondary_reset_n)
      else $error("watchdog expiry did not assert resets");

   restart_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      $rose(reset_out.primary_reset_n) |-> wdt_cnt == '0)
      else $error("watchdog count not restarted");

   edge_clear_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      wdi_edge |=> wdt_cnt == '0)
      else $error("activity edge did not restart count");

   limit_sel_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      sel_hi_s && sel_lo_s |-> wdt_limit == CNT_W'(WDT3_CYC))
      else $error("wrong timeout for select 11");

   hold2_len_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      state == ST_HOLD2 && hold_cnt == CNT_W'(SECONDARY_CYC - 1)
      && supply_ok && !wdt_expire |=> state == ST_RUN)
      else $error("secondary hold length wrong");

endmodule // swrm_monitor

// *** swrm_pkg.sv ***
package swrm_pkg;

   localparam int unsigned CLK_HZ = 10_000_000;

   // timing figures in microseconds, as printed
   localparam int unsigned PRIMARY_HOLD_US   = 50_000;
   localparam int unsigned SECONDARY_HOLD_US = 60_000;
   localparam int unsigned SECONDARY_EXTRA_US = 10_000;
   localparam int unsigned WDT_SEL0_US = 750;
   localparam int unsigned WDT_TIMEOUT_SELECT_LOW_US = 1_500;
   localparam int unsigned WDT_TIMEOUT_SELECT_HIGH_US = 12_500;
   localparam int unsigned WDT_SEL3_US = 25_000;

   // least times scale by whole cycles per microsecond, rate rounded down
   localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
   localparam int unsigned PRIMARY_HOLD_CYC   = PRIMARY_HOLD_US * CYC_PER_US;
   localparam int unsigned SECONDARY_EXTRA_CYC = SECONDARY_EXTRA_US * CYC_PER_US;
   localparam int unsigned WDT_SEL0_CYC = WDT_SEL0_US * CYC_PER_US;
   localparam int unsigned WDT_TIMEOUT_SELECT_LOW_CYC = WDT_TIMEOUT_SELECT_LOW_US * CYC_PER_US;
   localparam int unsigned WDT_TIMEOUT_SELECT_HIGH_CYC = WDT_TIMEOUT_SELECT_HIGH_US * CYC_PER_US;
   localparam int unsigned WDT_SEL3_CYC = WDT_SEL3_US * CYC_PER_US;

   localparam int CNT_W = 24;

   typedef struct packed {
      logic timeout_select_high;
      logic timeout_select_low;
   } swrm_sel_type;

   typedef struct packed {
      logic primary_reset_n;
      logic secondary_reset_n;
   } swrm_rst_type;

   typedef enum logic [3:0] {
      ST_RUN     = 4'b0001,
      ST_FAULT   = 4'b0010,
      ST_HOLD1   = 4'b0100,
      ST_HOLD2   = 4'b1000
   } swrm_state_type;

endpackage

// *** swrm_sync.sv ***
module swrm_sync
(
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic arst_n,
   // asynchronous level in, synchronised out
   input  wire logic async_in,
   output logic      sync_out
);
   logic stage1;

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         stage1   <= 1'b0;
         sync_out <= 1'b0;
      end
      else
      begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end
endmodule // swrm_sync

// *** swrm_cpu.sv ***
module swrm_cpu
   import swrm_pkg::*;
#(
   parameter int PER = 3
)
(
   // clock and bench control
   input  wire logic                   sys_clk,
   input  wire logic                   run,
   input  wire logic [1:0]             sel,
   // monitor side
   input  wire swrm_pkg::swrm_rst_type reset_out,
   output swrm_pkg::swrm_sel_type      timeout_sel,
   output logic                        watchdog_activity_line
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt = 0;
   initial
   begin
      timeout_sel = '0;
      watchdog_activity_line = 1'b0;
   end
   // stalled processor: no toggles while held in reset
   always @(negedge sys_clk)
   begin
      timeout_sel <= swrm_sel_type'(sel);
      if (run && reset_out.primary_reset_n === 1'b1)
      begin
         cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
         if (cnt == PER - 1)
            watchdog_activity_line <= ~watchdog_activity_line;
      end
   end
endmodule // swrm_cpu

// *** tb.sv ***
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import swrm_pkg::*;
   localparam int P = 50;
   localparam int S = 20;
   int wdt [4] = '{10, 20, 30, 40};
   logic         sys_clk = 1'b0;
   logic         arst_n = 1'b0;
   logic         supply = 1'b1;
   logic         run = 1'b1;
   logic [1:0]   sel = 2'h0;
   logic         prev_w = 1'b0;
   swrm_sel_type tsel;
   swrm_rst_type rst;
   logic         wdl;
   int           err_total = 0;
   int           total_checks = 0;
   int           cyc = 0;
   int           last_edge = 0;
   always #50 sys_clk = ~sys_clk;
   swrm_monitor #(.PRIMARY_CYC(P), .SECONDARY_CYC(S), .WDT0_CYC(10),
      .WDT1_CYC(20), .WDT2_CYC(30), .WDT3_CYC(40)) uut (.sys_clk(sys_clk),
      .arst_n(arst_n), .monitored_supply(supply),
      .watchdog_activity_line(wdl), .timeout_sel(tsel), .reset_out(rst));
   swrm_cpu cpu (.sys_clk(sys_clk), .run(run), .sel(sel),
      .reset_out(rst), .timeout_sel(tsel), .watchdog_activity_line(wdl));
   task automatic chk(input bit ok, input string m);
      total_checks++;
      if (!ok)
      begin
         err_total++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask
   task automatic wait_pri(input logic v, output int n);
      n = 0;
      while (rst.primary_reset_n !== v && n < 2000)
      begin
         @(negedge sys_clk);
         n++;
      end
      if (n >= 2000)
         chk(1'b0, "primary reset stuck");
   endtask
   task automatic wait_sec(output int n);
      n = 0;
      while (rst.secondary_reset_n !== 1'b1 && n < 2000)
      begin
         @(negedge sys_clk);
         n++;
      end
      if (n >= 2000)
         chk(1'b0, "secondary reset stuck");
   endtask
   task automatic t_supply;
      int n;
      run = 1'b1;
      wait_pri(1'b1, n);
      wait_sec(n);
      @(negedge sys_clk);
      supply = 1'b0;
      wait_pri(1'b0, n);
      chk(n <= 4 && rst.secondary_reset_n === 1'b0, "supply fault");
      repeat (100) @(negedge sys_clk);
      chk(rst === 2'b00, "held in fault");
      supply = 1'b1;
      wait_pri(1'b1, n);
      chk(n >= P && n <= P + 4, "primary release");
      wait_sec(n);
      chk(n == S, "secondary release");
   endtask
   task automatic t_toggle;
      sel = 2'h0;
      run = 1'b1;
      repeat (200) @(negedge sys_clk);
      chk(rst === 2'b11, "reset despite toggling");
   endtask
   task automatic t_wdog(input int s);
      int n;
      int m;
      sel = s[1:0];
      run = 1'b1;
      repeat (10) @(negedge sys_clk);
      run = 1'b0;
      wait_pri(1'b0, n);
      n = cyc - last_edge;
      chk(n >= wdt[s] && n <= wdt[s] + 6, "timeout length");
      chk(rst.secondary_reset_n === 1'b0, "both on timeout");
      wait_pri(1'b1, n);
      chk(n >= P && n <= P + 3, "watchdog hold");
      n = 0;
      m = 0;
      while (rst.primary_reset_n === 1'b1 && n < 2000)
      begin
         @(negedge sys_clk);
         n++;
         if (rst.secondary_reset_n === 1'b1 && m == 0)
            m = n;
      end
      chk(n == wdt[s], "restart at release");
      chk(m == ((wdt[s] > S) ? S : 0), "secondary extra");
      run = 1'b1;
      wait_pri(1'b1, n);
      wait_sec(n);
   endtask
   task automatic results;
      if (err_total == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   always @(negedge sys_clk)
   begin
      prev_w <= wdl;
      if (wdl !== prev_w)
         last_edge <= cyc;
   end
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      if (cyc > 20000)
      begin
         err_total++;
         results();
      end
   end
   initial
   begin
      repeat (10) @(negedge sys_clk);
      arst_n = 1'b1;
      t_supply();
      t_toggle();
      for (int s = 0; s < 4; s++)
         t_wdog(s);
      results();
   end
endmodule // tb
